// ==== design/ssm_top.v ====
// sleep state error mask bank: five mask registers and the event gating they steer
`timescale 1ns/1ps
`include "ssm_map.vh"

// Function
// - An eight-bit light-sleep input mask, reset to all ones, hides input n errors in light sleep.
// - A light-sleep fan mask, bits 0 to 3 for fans 1 to 4, resets to 0Fh.
// - An eight-bit suspend-to-RAM input mask, reset to all ones, hides input n errors there.
// - A suspend-to-RAM fan mask, bits 0 to 3 for fans 1 to 4, resets to 0Fh.
// - Suspend voltage mask bits 1 and 2 hide analog inputs 13 and 14; the register resets to 07h.
// - Suspend voltage mask bit 3 hides zone 1 and 2 temperature and diode fault errors.
// - Light-sleep masks act only at state 01, suspend masks only at 10, plus fixed standard masks.
// - With the global start bit clear every error event is masked.
module ssm_top #(
   parameter [7:0] STD_LS_INPUT = 8'h00,
   parameter [3:0] STD_LS_FAN = 4'h0,
   parameter [7:0] STD_SR_INPUT = 8'h00,
   parameter [3:0] STD_SR_FAN = 4'h0,
   parameter [1:0] STD_SR_ANALOG = 2'h0,
   parameter STD_SR_THERM = 1'b0
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_rd_i,
   output wire [7:0] reg_rdata_o,
   output wire reg_rvalid_o,
   input wire [1:0] sleep_state_field_i,
   input wire start_i,
   input wire [7:0] general_input_err_i,
   input wire [3:0] fan_err_i,
   input wire analog_input_13_err_i,
   input wire analog_input_14_err_i,
   input wire [1:0] zone_temp_err_i,
   input wire [1:0] zone_diode_err_i,
   output wire [7:0] general_input_err_o,
   output wire [3:0] fan_err_o,
   output wire analog_input_13_err_o,
   output wire analog_input_14_err_o,
   output wire [1:0] zone_temp_err_o,
   output wire [1:0] zone_diode_err_o
);

   ////////////////////////////////////////////////////////////////////////////
   // register write decode

   wire wr_ls_input;
   wire wr_ls_tach;
   wire wr_sr_input;
   wire wr_sr_tach;
   wire wr_sr_volt;
   wire [7:0] ls_input_mask;
   wire [7:0] ls_tach_mask;
   wire [7:0] sr_input_mask;
   wire [7:0] sr_tach_mask;
   wire [7:0] sr_volt_mask;

   assign wr_ls_input = reg_wr_i && (reg_addr_i == `SSM_OFS_LS_INPUT);
   assign wr_ls_tach = reg_wr_i && (reg_addr_i == `SSM_OFS_LS_TACH);
   assign wr_sr_input = reg_wr_i && (reg_addr_i == `SSM_OFS_SR_INPUT);
   assign wr_sr_tach = reg_wr_i && (reg_addr_i == `SSM_OFS_SR_TACH);
   assign wr_sr_volt = reg_wr_i && (reg_addr_i == `SSM_OFS_SR_VOLT);

   ////////////////////////////////////////////////////////////////////////////
   // mask registers

   ssm_mask_reg #(
      .RESET_VAL(`SSM_RST_LS_INPUT),
      .WRITE_MASK(`SSM_WR_INPUT)
   ) u_ls_input (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_ls_input),
      .wdata_i(reg_wdata_i),
      .value_o(ls_input_mask)
   );

   ssm_mask_reg #(
      .RESET_VAL(`SSM_RST_LS_TACH),
      .WRITE_MASK(`SSM_WR_TACH)
   ) u_ls_tach (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_ls_tach),
      .wdata_i(reg_wdata_i),
      .value_o(ls_tach_mask)
   );

   ssm_mask_reg #(
      .RESET_VAL(`SSM_RST_SR_INPUT),
      .WRITE_MASK(`SSM_WR_INPUT)
   ) u_sr_input (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_sr_input),
      .wdata_i(reg_wdata_i),
      .value_o(sr_input_mask)
   );

   ssm_mask_reg #(
      .RESET_VAL(`SSM_RST_SR_TACH),
      .WRITE_MASK(`SSM_WR_TACH)
   ) u_sr_tach (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_sr_tach),
      .wdata_i(reg_wdata_i),
      .value_o(sr_tach_mask)
   );

   // bit 0 is stored as written; clearing it is a software fault, not policed here
   ssm_mask_reg #(
      .RESET_VAL(`SSM_RST_SR_VOLT),
      .WRITE_MASK(`SSM_WR_VOLT)
   ) u_sr_volt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_sr_volt),
      .wdata_i(reg_wdata_i),
      .value_o(sr_volt_mask)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register read, answered one cycle after the strobe

   reg [7:0] rdata_q;
   reg [7:0] rdata_d;
   reg rvalid_q;

   always @*
   begin
      case (reg_addr_i)
         `SSM_OFS_LS_INPUT: rdata_d = ls_input_mask;
         `SSM_OFS_LS_TACH: rdata_d = ls_tach_mask;
         `SSM_OFS_SR_INPUT: rdata_d = sr_input_mask;
         `SSM_OFS_SR_TACH: rdata_d = sr_tach_mask;
         `SSM_OFS_SR_VOLT: rdata_d = sr_volt_mask;
         default: rdata_d = `SSM_RD_NONE;
      endcase
   end

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_q <= `SSM_RD_NONE;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= reg_rd_i;
         if (reg_rd_i)
         begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;

   ////////////////////////////////////////////////////////////////////////////
   // effective masks for the present sleep state

   reg [7:0] input_hide;
   reg [3:0] fan_hide;
   reg [1:0] analog_hide;
   reg therm_hide;

   // deep sleep masks live outside this bank, so state 11 passes events through
   always @*
   begin
      input_hide = 8'h00;
      fan_hide = 4'h0;
      analog_hide = 2'h0;
      therm_hide = 1'b0;
      case (sleep_state_field_i)
         `SSM_STATE_AWAKE:
         begin
            input_hide = 8'h00;
         end
         `SSM_STATE_LIGHT:
         begin
            input_hide = ls_input_mask | STD_LS_INPUT;
            fan_hide = ls_tach_mask[3:0] | STD_LS_FAN;
         end
         `SSM_STATE_SUSPEND:
         begin
            input_hide = sr_input_mask | STD_SR_INPUT;
            fan_hide = sr_tach_mask[3:0] | STD_SR_FAN;
            analog_hide = {sr_volt_mask[`SSM_BIT_AN14],
                           sr_volt_mask[`SSM_BIT_AN13]} | STD_SR_ANALOG;
            therm_hide = sr_volt_mask[`SSM_BIT_THERM] | STD_SR_THERM;
         end
         default:
         begin
            input_hide = 8'h00;
         end
      endcase
      if (!start_i)
      begin
         input_hide = 8'hFF;
         fan_hide = 4'hF;
         analog_hide = 2'h3;
         therm_hide = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gated events, registered so the outputs come from flops

   reg [7:0] input_err_q;
   reg [3:0] fan_err_q;
   reg an13_err_q;
   reg an14_err_q;
   reg [1:0] temp_err_q;
   reg [1:0] diode_err_q;

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         input_err_q <= 8'h00;
         fan_err_q <= 4'h0;
         an13_err_q <= 1'b0;
         an14_err_q <= 1'b0;
         temp_err_q <= 2'h0;
         diode_err_q <= 2'h0;
      end
      else
      begin
         input_err_q <= general_input_err_i & ~input_hide;
         fan_err_q <= fan_err_i & ~fan_hide;
         an13_err_q <= analog_input_13_err_i & ~analog_hide[0];
         an14_err_q <= analog_input_14_err_i & ~analog_hide[1];
         // one bit covers both zones and both error kinds
         temp_err_q <= zone_temp_err_i & ~{2{therm_hide}};
         diode_err_q <= zone_diode_err_i & ~{2{therm_hide}};
      end
   end

   assign general_input_err_o = input_err_q;
   assign fan_err_o = fan_err_q;
   assign analog_input_13_err_o = an13_err_q;
   assign analog_input_14_err_o = an14_err_q;
   assign zone_temp_err_o = temp_err_q;
   assign zone_diode_err_o = diode_err_q;

endmodule // ssm_top

// ==== design/ssm_map.vh ====
// register map and field constants for the sleep state error mask bank
`ifndef SSM_MAP_VH
`define SSM_MAP_VH

// register offsets
`define SSM_OFS_LS_INPUT 8'hE5
`define SSM_OFS_LS_TACH 8'hE6
`define SSM_OFS_SR_INPUT 8'hE7
`define SSM_OFS_SR_TACH 8'hE8
`define SSM_OFS_SR_VOLT 8'hE9

// reset values
`define SSM_RST_LS_INPUT 8'hFF
`define SSM_RST_LS_TACH 8'h0F
`define SSM_RST_SR_INPUT 8'hFF
`define SSM_RST_SR_TACH 8'h0F
`define SSM_RST_SR_VOLT 8'h07

// writable bits per register
`define SSM_WR_INPUT 8'hFF
`define SSM_WR_TACH 8'h0F
`define SSM_WR_VOLT 8'h0F

// value returned for an unmapped offset
`define SSM_RD_NONE 8'h00

// sleep state field codes
`define SSM_STATE_AWAKE 2'h0
`define SSM_STATE_LIGHT 2'h1
`define SSM_STATE_SUSPEND 2'h2
`define SSM_STATE_DEEP 2'h3

// field positions in the suspend voltage/thermal mask
`define SSM_BIT_AN13 1
`define SSM_BIT_AN14 2
`define SSM_BIT_THERM 3

// field widths
`define SSM_INPUT_W 8
`define SSM_FAN_W 4
`define SSM_ZONE_W 2

`endif

// ==== design/ssm_mask_reg.v ====
// one software mask register with fixed read-as-reset bits
`timescale 1ns/1ps

module ssm_mask_reg #(
   parameter [7:0] RESET_VAL = 8'hFF,
   parameter [7:0] WRITE_MASK = 8'hFF
) (
   input wire clk_i,
   input wire rst_i,
   input wire wr_i,
   input wire [7:0] wdata_i,
   output wire [7:0] value_o
);

   reg [7:0] value_q;
   wire [7:0] value_d;

   // bits outside the write mask never move, so they read back as their reset value
   assign value_d = (wdata_i & WRITE_MASK) | (RESET_VAL & ~WRITE_MASK);

   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         value_q <= RESET_VAL;
      end
      else if (wr_i)
      begin
         value_q <= value_d;
      end
   end

   assign value_o = value_q;

endmodule // ssm_mask_reg

// ==== test/ssm_check_checker.sv ====
// port-level assertions for the sleep state error mask bank
`timescale 1ns/1ps
module ssm_check (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] reg_addr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire reg_rvalid_o,
   input wire [1:0] sleep_state_field_i,
   input wire start_i,
   input wire [7:0] general_input_err_i,
   input wire [7:0] general_input_err_o,
   input wire [3:0] fan_err_o,
   input wire analog_input_13_err_i,
   input wire analog_input_13_err_o,
   input wire analog_input_14_err_o,
   input wire [1:0] zone_temp_err_o,
   input wire [1:0] zone_diode_err_o
);
default clocking cb @(posedge clk_i);
endclocking
default disable iff (rst_i);
////////////////////////////////////////////////////////////////////////////////
a_start_hides: assert property (!start_i |=> {general_input_err_o, fan_err_o,
   analog_input_13_err_o, analog_input_14_err_o, zone_temp_err_o, zone_diode_err_o} == 18'h00000)
   else $error("event passed while stopped");
a_awake_pass: assert property (start_i && sleep_state_field_i == 2'h0 |=>
   general_input_err_o == $past(general_input_err_i)) else $error("awake input masked");
a_light_analog: assert property (start_i && sleep_state_field_i == 2'h1 |=>
   analog_input_13_err_o == $past(analog_input_13_err_i)) else $error("light analog masked");
a_mask_only: assert property (1'b1 |=>
   (general_input_err_o & ~$past(general_input_err_i)) == 8'h00) else $error("event invented");
a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read unanswered");
a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray rvalid");
a_tach_upper: assert property (reg_rvalid_o && ($past(reg_addr_i) == 8'hE6 ||
   $past(reg_addr_i) == 8'hE8) |-> reg_rdata_o[7:4] == 4'h0) else $error("fan upper bits set");
a_unmapped_zero: assert property (reg_rvalid_o && ($past(reg_addr_i) < 8'hE5 ||
   $past(reg_addr_i) > 8'hE9) |-> reg_rdata_o == 8'h00) else $error("unmapped read nonzero");
endmodule // ssm_check

// ==== test/ssm_top_bench.sv ====
// self-checking bench for the sleep state error mask bank
`timescale 1ns/1ps
module ssm_top_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] state = 2'h0;
   logic start = 1'b0;
   logic [17:0] ev = 18'h00000;
   wire [7:0] rdata;
   wire rvalid;
   wire [17:0] eo;
   int errors = 0;
   int num_checks = 0;
   always #4 clk_i = ~clk_i;
   ssm_top i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sleep_state_field_i(state),
      .start_i(start), .general_input_err_i(ev[17:10]), .fan_err_i(ev[9:6]),
      .analog_input_13_err_i(ev[5]), .analog_input_14_err_i(ev[4]), .zone_temp_err_i(ev[3:2]),
      .zone_diode_err_i(ev[1:0]), .general_input_err_o(eo[17:10]), .fan_err_o(eo[9:6]),
      .analog_input_13_err_o(eo[5]), .analog_input_14_err_o(eo[4]),
      .zone_temp_err_o(eo[3:2]), .zone_diode_err_o(eo[1:0])
   );
////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      // wait past the edge so the registered answer has landed
      #1;
      chk({9'h000, rvalid, rdata}, {10'h001, e});
   endtask
   task automatic run_ev(input logic [1:0] s, input logic go, input logic [17:0] v,
      input logic [17:0] e);
      @(posedge clk_i);
      state <= s;
      start <= go;
      ev <= v;
      @(posedge clk_i);
      #1;
      chk(eo, e);
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values;
      rd_reg(8'hE5, 8'hFF);
      rd_reg(8'hE6, 8'h0F);
      rd_reg(8'hE7, 8'hFF);
      rd_reg(8'hE8, 8'h0F);
      rd_reg(8'hE9, 8'h07);
      rd_reg(8'hE4, 8'h00);
   endtask
   task automatic t_write_back;
      wr_reg(8'hE6, 8'hF5);
      rd_reg(8'hE6, 8'h05);
      wr_reg(8'hE8, 8'hA5);
      rd_reg(8'hE8, 8'h05);
      wr_reg(8'hE5, 8'h5A);
      rd_reg(8'hE5, 8'h5A);
      wr_reg(8'hE7, 8'hC3);
      rd_reg(8'hE7, 8'hC3);
      wr_reg(8'hE9, 8'hFF);
      rd_reg(8'hE9, 8'h0F);
      wr_reg(8'hEA, 8'h55);
      rd_reg(8'hEA, 8'h00);
   endtask
   task automatic t_light;
      run_ev(2'h1, 1'b1, 18'h3FFFF, {8'hA5, 4'hA, 6'h3F});
   endtask
   task automatic t_suspend;
      run_ev(2'h2, 1'b1, 18'h3FFFF, {8'h3C, 4'hA, 6'h00});
      wr_reg(8'hE9, 8'h03);
      run_ev(2'h2, 1'b1, 18'h3FFFF, {8'h3C, 4'hA, 6'h1F});
      wr_reg(8'hE9, 8'h0D);
      run_ev(2'h2, 1'b1, 18'h3FFFF, {8'h3C, 4'hA, 6'h20});
   endtask
   task automatic t_other_states;
      run_ev(2'h0, 1'b1, 18'h2A5C3, 18'h2A5C3);
      run_ev(2'h3, 1'b1, 18'h3FFFF, 18'h3FFFF);
      run_ev(2'h1, 1'b0, 18'h3FFFF, 18'h00000);
      run_ev(2'h0, 1'b0, 18'h3FFFF, 18'h00000);
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset_values();
      t_write_back();
      t_light();
      t_suspend();
      t_other_states();
      give_verdict();
   end
   // whole run is about 76 cycles, so this only trips on a hang
   initial
   begin
      repeat (2000) @(posedge clk_i);
      errors++;
      $display("MISMATCH %0t watchdog expired before the tests ended", $time);
      give_verdict();
   end
endmodule // ssm_top_bench
bind ssm_top ssm_check i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .sleep_state_field_i(sleep_state_field_i), .start_i(start_i),
   .general_input_err_i(general_input_err_i), .general_input_err_o(general_input_err_o),
   .fan_err_o(fan_err_o), .analog_input_13_err_i(analog_input_13_err_i),
   .analog_input_13_err_o(analog_input_13_err_o), .analog_input_14_err_o(analog_input_14_err_o),
   .zone_temp_err_o(zone_temp_err_o), .zone_diode_err_o(zone_diode_err_o)
);
